// >>> verilog/asc_pkg.sv
// Register map, field layouts and converter-side request type of the conversion sequence control block.
`default_nettype none
package asc_pkg;
    localparam int NPOS = 16;
    localparam int RES_W = 12;
    localparam int IDX_W = 6;
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h03;
    localparam logic [IDX_W-1:0] IDX_TIMING = 6'h04;
    localparam logic [IDX_W-1:0] IDX_START = 6'h05;
    localparam logic [IDX_W-1:0] IDX_CMP = 6'h06;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h07;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 6'h08;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h09;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_RESULT = 6'h10;
    localparam logic [3:0] ADDR_HI_ZERO = 4'h0;
    localparam logic [1:0] ADDR_LO_ZERO = 2'h0;
    localparam logic [7:0] TIMING_RST = 8'h00;
    localparam logic [5:0] START_RST = 6'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] FRZ_FINISH = 2'b10;
    localparam logic [1:0] FRZ_IMMED = 2'b11;
    localparam int IRQ_W = 2;
    localparam int IRQ_SEQ_DONE = 0;
    localparam int IRQ_COMPARE = 1;
    localparam int DIV_W = 6;
    localparam int SMP_W = 5;

    typedef struct packed {
        logic [2:0] sample_time_sel;
        logic [4:0] clock_prescale;
    } asc_timing_t;

    typedef struct packed {
        logic scan;
        logic multi_channel_sel;
        logic [3:0] chan;
    } asc_start_t;

    typedef struct packed {
        logic [3:0] seq_len;
        logic compare_irq_enable;
        logic fast_flag_clear;
        logic freeze_behaviour_hi;
        logic freeze_behaviour_lo;
    } asc_ctrl_t;

    typedef struct packed {
        logic sampling;
        logic convert_start;
        logic [3:0] channel;
    } asc_conv_req_t;

    // Sample length in conversion-clock cycles; the undefined code 111 takes the longest length.
    function automatic logic [SMP_W-1:0] asc_sample_cycles(input logic [2:0] code);
        logic [SMP_W-1:0] n;
        n = 5'h14;
        case (code)
            3'h0: n = 5'h04;
            3'h1: n = 5'h06;
            3'h2: n = 5'h08;
            3'h3: n = 5'h0A;
            3'h4: n = 5'h0C;
            3'h5: n = 5'h10;
            default: n = 5'h14;
        endcase
        return n;
    endfunction
endpackage
`default_nettype wire

// >>> verilog/asc_seq_ctrl.sv
// Conversion sequencer with APB register file, complete flags, compare and interrupt logic.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Single or continuous, one or many channels.
// - Entering stop aborts the running sequence.
// - Leaving stop restarts aborted sequence, clearing flags.
// - Wait state changes nothing.
// - Freeze field picks continue, finish, or halt.
// - Timing register write aborts the sequence.
// - Sample field picks 4 to 20 cycles.
// - Conversion clock is bus over 2(prescale+1).
// - Sixteen complete flags indexed by sequence position.
// - Position k result lands in result k.
// - Compare gates flag, requests interrupt, drops result.
// - Flags clear by start, write one, or access.
// - Start clear beats set; other clears lose.
// - Start register write aborts and starts anew.
// - Multi-channel increments channel, wrapping to zero.
module asc_seq_ctrl
    import asc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_mode,
    input wire logic freeze_mode,
    output logic conv_clk,
    output var asc_conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_result,
    output logic irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} asc_state_t;

    asc_state_t state_q, state_d;
    asc_timing_t timing_q, timing_d;
    asc_start_t start_q, start_d;
    asc_ctrl_t ctrl_q, ctrl_d;
    logic [NPOS-1:0] auto_compare_enable_q, auto_compare_enable_d;
    logic [NPOS-1:0] compare_greater_sel_q, compare_greater_sel_d;
    logic [NPOS-1:0] flag_q, flag_d;
    logic [RES_W-1:0] res_q [NPOS];
    logic [RES_W-1:0] res_d [NPOS];
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [IRQ_W-1:0] irq_en_q, irq_en_d;
    logic [3:0] pos_q, pos_d;
    logic [3:0] chan_q, chan_d;
    logic scan_q, scan_d;
    logic multi_channel_sel_q, multi_channel_sel_d;
    logic [SMP_W-1:0] smp_q, smp_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic cclk_q, cclk_d;
    logic cstart_q, cstart_d;
    logic aborted_q, aborted_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic stop_m_q, stop_s_q, stop_p_q;
    logic frz_m_q, frz_s_q;

    logic setup, wr, rd, mapped;
    logic [IDX_W-1:0] idx;
    logic wr_timing, wr_start, wr_flags, wr_ctrl;
    logic stop_rise, stop_fall, restart, start_clr, tick, hold, done_ok, cmp_true, last;
    logic [NPOS-1:0] rd_res, wr_res, set_f, soft_clr;
    logic [1:0] frz_sel;
    asc_start_t start_src;

    // The bus decode is shared by the setup-phase read mux and the access-phase side effects.
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign idx = paddr[7:2];
    assign mapped = (paddr[11:8] == ADDR_HI_ZERO) && (paddr[1:0] == ADDR_LO_ZERO)
        && ((idx >= IDX_CTRL && idx <= IDX_FLAGS) || (idx >= IDX_RESULT && idx <= IDX_RESULT + IDX_W'(NPOS - 1)));
    assign wr_timing = wr && mapped && idx == IDX_TIMING;
    assign wr_start = wr && mapped && idx == IDX_START;
    assign wr_flags = wr && mapped && idx == IDX_FLAGS;
    assign wr_ctrl = wr && mapped && idx == IDX_CTRL;
    assign stop_rise = stop_s_q & ~stop_p_q;
    assign stop_fall = ~stop_s_q & stop_p_q;
    assign restart = stop_fall & aborted_q;
    assign start_clr = wr_start | restart;
    assign frz_sel = {ctrl_q.freeze_behaviour_hi, ctrl_q.freeze_behaviour_lo};
    // One conversion-clock period ends when the high half of the divided clock expires.
    assign tick = (div_q == {1'b0, timing_q.clock_prescale}) & cclk_q;
    // The finish setting halts only before a new sample has begun counting.
    assign hold = frz_s_q & ((frz_sel == FRZ_IMMED) | ((frz_sel == FRZ_FINISH) & (smp_q == '0)));
    assign cmp_true = compare_greater_sel_q[pos_q] ? (conv_result > res_q[pos_q]) : (conv_result <= res_q[pos_q]);
    assign done_ok = (state_q == ST_CONVERT) & conv_done;
    assign last = pos_q == (ctrl_q.seq_len - 4'h1);
    assign start_src = wr_start ? asc_start_t'(pwdata[5:0]) : start_q;

    genvar g;
    generate
        for (g = 0; g < NPOS; g++)
        begin : g_pos
            assign rd_res[g] = rd && mapped && idx == (IDX_RESULT + IDX_W'(g));
            assign wr_res[g] = wr && mapped && idx == (IDX_RESULT + IDX_W'(g));
            assign set_f[g] = done_ok && pos_q == 4'(g) && (~auto_compare_enable_q[g] | cmp_true);
            assign soft_clr[g] = (wr_flags & pwdata[g] & ~ctrl_q.fast_flag_clear)
                | (ctrl_q.fast_flag_clear & ~auto_compare_enable_q[g] & rd_res[g])
                | (ctrl_q.fast_flag_clear & auto_compare_enable_q[g] & wr_res[g]);
            // Start clears win over the set; the other clears lose to it.
            assign flag_d[g] = start_clr ? 1'b0 : (set_f[g] | (flag_q[g] & ~soft_clr[g]));
            // A conversion store beats a software write in the same cycle; compare values are kept.
            assign res_d[g] = (done_ok && pos_q == 4'(g) && ~auto_compare_enable_q[g]) ? conv_result
                : (wr_res[g] ? pwdata[RES_W-1:0] : res_q[g]);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    flag_q[g] <= 1'b0;
                    res_q[g] <= '0;
                end
                else
                begin
                    flag_q[g] <= flag_d[g];
                    res_q[g] <= res_d[g];
                end
            end
        end
    endgenerate

    always_comb
    begin
        timing_d = wr_timing ? asc_timing_t'(pwdata[7:0]) : timing_q;
        start_d = start_src;
        ctrl_d = wr_ctrl ? asc_ctrl_t'(pwdata[7:0]) : ctrl_q;
        auto_compare_enable_d = auto_compare_enable_q;
        compare_greater_sel_d = compare_greater_sel_q;
        if (wr && mapped && idx == IDX_CMP)
        begin
            auto_compare_enable_d = pwdata[15:0];
            compare_greater_sel_d = pwdata[31:16];
        end
        irq_en_d = (wr && mapped && idx == IDX_IRQ_EN) ? pwdata[IRQ_W-1:0] : irq_en_q;
        irq_stat_d = irq_stat_q;
        if (wr && mapped && idx == IDX_IRQ_CLR)
        begin
            irq_stat_d = irq_stat_q & ~pwdata[IRQ_W-1:0];
        end
        if (done_ok && last)
        begin
            irq_stat_d[IRQ_SEQ_DONE] = 1'b1;
        end
        if (done_ok && auto_compare_enable_q[pos_q] && cmp_true && ctrl_q.compare_irq_enable)
        begin
            irq_stat_d[IRQ_COMPARE] = 1'b1;
        end
    end

    // The divider runs in every power state alike, so wait mode needs no special handling.
    always_comb
    begin
        cclk_d = cclk_q;
        div_d = div_q + 6'h01;
        if (div_q == {1'b0, timing_q.clock_prescale})
        begin
            div_d = '0;
            cclk_d = ~cclk_q;
        end
    end

    always_comb
    begin
        state_d = state_q;
        pos_d = pos_q;
        chan_d = chan_q;
        scan_d = scan_q;
        multi_channel_sel_d = multi_channel_sel_q;
        smp_d = smp_q;
        cstart_d = 1'b0;
        aborted_d = aborted_q;
        if (stop_rise && state_q != ST_IDLE)
        begin
            aborted_d = 1'b1;
        end
        if (restart || wr_start)
        begin
            aborted_d = 1'b0;
        end
        if (start_clr && !stop_s_q)
        begin
            state_d = ST_SAMPLE;
            pos_d = '0;
            smp_d = '0;
            chan_d = start_src.chan;
            scan_d = start_src.scan;
            multi_channel_sel_d = start_src.multi_channel_sel;
        end
        else if (wr_timing || wr_start || stop_s_q)
        begin
            state_d = ST_IDLE;
            smp_d = '0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    state_d = ST_IDLE;
                end
                ST_SAMPLE:
                begin
                    if (tick && !hold)
                    begin
                        smp_d = smp_q + 5'h01;
                        if (smp_q + 5'h01 == asc_sample_cycles(timing_q.sample_time_sel))
                        begin
                            state_d = ST_CONVERT;
                            cstart_d = 1'b1;
                            smp_d = '0;
                        end
                    end
                end
                ST_CONVERT:
                begin
                    if (conv_done)
                    begin
                        state_d = ST_SAMPLE;
                        if (last)
                        begin
                            pos_d = '0;
                            chan_d = start_q.chan;
                            state_d = scan_q ? ST_SAMPLE : ST_IDLE;
                        end
                        else
                        begin
                            pos_d = pos_q + 4'h1;
                            chan_d = multi_channel_sel_q ? chan_q + 4'h1 : chan_q;
                        end
                    end
                end
            endcase
        end
    end

    // Read data is captured in the setup phase so that prdata leaves a flip-flop.
    always_comb
    begin
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (setup)
        begin
            prdata_d = '0;
            pslverr_d = ~mapped;
            if (mapped)
            begin
                if (idx >= IDX_RESULT)
                begin
                    prdata_d = {20'h00000, res_q[idx[3:0]]};
                end
                else
                begin
                    unique case (idx)
                        IDX_CTRL: prdata_d = {24'h000000, ctrl_q};
                        IDX_TIMING: prdata_d = {24'h000000, timing_q};
                        IDX_START: prdata_d = {26'h0, start_q};
                        IDX_CMP: prdata_d = {compare_greater_sel_q, auto_compare_enable_q};
                        IDX_IRQ_STAT: prdata_d = {30'h0, irq_stat_q};
                        IDX_IRQ_EN: prdata_d = {30'h0, irq_en_q};
                        IDX_FLAGS: prdata_d = {16'h0000, flag_q};
                        default: prdata_d = '0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            timing_q <= TIMING_RST;
            start_q <= START_RST;
            ctrl_q <= CTRL_RST;
            auto_compare_enable_q <= '0;
            compare_greater_sel_q <= '0;
            irq_stat_q <= '0;
            irq_en_q <= '0;
            pos_q <= '0;
            chan_q <= '0;
            scan_q <= 1'b0;
            multi_channel_sel_q <= 1'b0;
            smp_q <= '0;
            div_q <= '0;
            cclk_q <= 1'b0;
            cstart_q <= 1'b0;
            aborted_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
            stop_m_q <= 1'b0;
            stop_s_q <= 1'b0;
            stop_p_q <= 1'b0;
            frz_m_q <= 1'b0;
            frz_s_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            timing_q <= timing_d;
            start_q <= start_d;
            ctrl_q <= ctrl_d;
            auto_compare_enable_q <= auto_compare_enable_d;
            compare_greater_sel_q <= compare_greater_sel_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
            pos_q <= pos_d;
            chan_q <= chan_d;
            scan_q <= scan_d;
            multi_channel_sel_q <= multi_channel_sel_d;
            smp_q <= smp_d;
            div_q <= div_d;
            cclk_q <= cclk_d;
            cstart_q <= cstart_d;
            aborted_q <= aborted_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            stop_m_q <= stop_mode;
            stop_s_q <= stop_m_q;
            stop_p_q <= stop_s_q;
            frz_m_q <= freeze_mode;
            frz_s_q <= frz_m_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q;
    assign conv_clk = cclk_q;
    assign conv_req = '{sampling: state_q == ST_SAMPLE, convert_start: cstart_q, channel: chan_q};
    assign irq = |(irq_stat_q & irq_en_q);
endmodule
`default_nettype wire

// >>> testbench/asc_seq_ctrl_props.sv
// Port-level checks of the conversion sequence control block.
`timescale 1ns/1ns
`default_nettype none
module asc_seq_ctrl_props
    import asc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop_mode,
    input wire logic freeze_mode,
    input wire logic conv_clk,
    input var asc_conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_result,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc_w;
    assign acc_w = psel && penable && pwrite;
    ready_high_a: assert property (pready) else $error("no ready");
    err_in_access_a: assert property (pslverr |-> psel && penable) else $error("stray error");
    misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr) else $error("no error");
    flags_ok_a: assert property (psel && !penable && paddr == 12'h028 |=> !pslverr) else $error("flags refused");
    start_pulse_a: assert property (conv_req.convert_start |=> !conv_req.convert_start) else $error("long start");
    sample_len_a: assert property (conv_req.convert_start |-> !conv_req.sampling
        && $past(conv_req.sampling) && $past(conv_req.sampling, 7)) else $error("short sample");
    start_write_a: assert property (acc_w && paddr == 12'h014 && !stop_mode && !freeze_mode
        && !$past(stop_mode) && !$past(stop_mode, 2) |=> conv_req.sampling) else $error("no sampling");
    timing_abort_a: assert property (acc_w && paddr == 12'h010
        |=> !conv_req.sampling && !conv_req.convert_start) else $error("no abort");
    stop_abort_a: assert property (stop_mode [*5] |-> !conv_req.sampling) else $error("stop ignored");
endmodule
`default_nettype wire

// >>> testbench/asc_core_model.sv
// Behavioural conversion core answering each launched conversion.
`timescale 1ns/1ns
`default_nettype none
module asc_core_model
    import asc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input var asc_conv_req_t conv_req,
    output logic conv_done,
    output logic [RES_W-1:0] conv_result
);
    logic [3:0] wait_q;
    logic [3:0] chan_q;
    logic busy_q;
    // Odd channels answer slowly; idle result lines keep changing so no stale value passes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            wait_q <= 4'h0;
            chan_q <= 4'h0;
            conv_done <= 1'b0;
            conv_result <= 12'h000;
        end
        else
        begin
            conv_done <= 1'b0;
            conv_result <= ~conv_result;
            if (conv_req.convert_start)
            begin
                busy_q <= 1'b1;
                chan_q <= conv_req.channel;
                wait_q <= conv_req.channel[0] ? 4'h6 : 4'h0;
            end
            else if (busy_q && wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
            else if (busy_q)
            begin
                busy_q <= 1'b0;
                conv_done <= 1'b1;
                conv_result <= {chan_q, 8'h5A};
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/asc_seq_ctrl_tb_top.sv
// Register-level test of the conversion sequence control block.
`timescale 1ns/1ns
`default_nettype none
module asc_seq_ctrl_tb_top
    import asc_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic stop_mode = 1'b0, freeze_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, conv_clk, conv_done, irq, re;
    asc_conv_req_t conv_req;
    logic [RES_W-1:0] conv_result;
    int mismatches = 0;
    int n_checks = 0;
    always #4 pclk = ~pclk;
    asc_seq_ctrl uut (.*);
    asc_core_model core (.*);
    function automatic logic [11:0] ad(input logic [IDX_W-1:0] i);
        return {ADDR_HI_ZERO, i, ADDR_LO_ZERO};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 20)
        begin
            @(posedge pclk);
            i++;
        end
        chk({31'h0, pready}, 32'h1);
        if (pready !== 1'b1)
            print_verdict();
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wflag(input logic [15:0] e);
        rd(ad(IDX_FLAGS));
        for (int i = 0; i < 200 && rv !== {16'h0, e}; i++)
            rd(ad(IDX_FLAGS));
        chk(rv, {16'h0, e});
        if (rv !== {16'h0, e})
            print_verdict();
    endtask
    task automatic chkirq(input logic e);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // The divided clock is watched on falling edges, where it has long settled.
    task automatic chkclk(input logic [31:0] e);
        logic c;
        logic [31:0] n;
        n = 32'h0;
        @(negedge pclk);
        c = conv_clk;
        while (conv_clk === c && n < 32'h40)
        begin
            @(negedge pclk);
            n++;
        end
        c = conv_clk;
        n = 32'h0;
        while (conv_clk === c && n < 32'h40)
        begin
            @(negedge pclk);
            n++;
        end
        chk(n, e);
        if (n == 32'h40)
            print_verdict();
        @(posedge pclk);
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ad(IDX_TIMING));
        chk(rv, 32'h0);
        wr(ad(IDX_TIMING), 32'h21);
        rd(ad(IDX_TIMING));
        chk(rv, 32'h21);
        chkclk(32'h2);
        rd(12'h029);
        chk({rv[30:0], re}, 32'h1);
        rd(ad(6'h20));
        chk({rv[30:0], re}, 32'h1);
        wr(ad(IDX_CTRL), 32'h40);
        for (int m = 0; m < 2; m++)
        begin
            wr(ad(IDX_START), m ? 32'h1E : 32'h0E);
            rd(ad(IDX_FLAGS));
            chk(rv, 32'h0);
            wflag(16'h000F);
            for (int k = 0; k < 4; k++)
            begin
                rd(ad(IDX_RESULT + k[5:0]));
                chk(rv, {20'h0, m ? 4'hE + k[3:0] : 4'hE, 8'h5A});
            end
        end
        wr(ad(IDX_FLAGS), 32'h0);
        rd(ad(IDX_FLAGS));
        chk(rv, 32'hF);
        wr(ad(IDX_FLAGS), 32'h1);
        rd(ad(IDX_FLAGS));
        chk(rv, 32'hE);
        wr(ad(IDX_CTRL), 32'h44);
        rd(ad(IDX_RESULT + 6'h01));
        rd(ad(IDX_FLAGS));
        chk(rv, 32'hC);
        wr(ad(IDX_CTRL), 32'h48);
        wr(ad(IDX_CMP), 32'h10001);
        wr(ad(IDX_RESULT), 32'h100);
        wr(ad(IDX_IRQ_EN), 32'h2);
        wr(ad(IDX_START), 32'h03);
        wflag(16'h000F);
        rd(ad(IDX_RESULT));
        chk(rv, 32'h100);
        chkirq(1'b1);
        rd(ad(IDX_IRQ_STAT));
        chk(rv, 32'h3);
        wr(ad(IDX_IRQ_EN), 32'h0);
        chkirq(1'b0);
        wr(ad(IDX_IRQ_EN), 32'h2);
        wr(ad(IDX_IRQ_CLR), 32'h2);
        chkirq(1'b0);
        wr(ad(IDX_RESULT), 32'hFFF);
        wr(ad(IDX_START), 32'h03);
        wflag(16'h000E);
        wr(ad(IDX_CMP), 32'h0);
        wr(ad(IDX_START), 32'h03);
        repeat (10) @(posedge pclk);
        wr(ad(IDX_TIMING), 32'h21);
        repeat (300) @(posedge pclk);
        rd(ad(IDX_FLAGS));
        chk(rv, 32'h0);
        wr(ad(IDX_START), 32'h03);
        wflag(16'h0001);
        stop_mode <= 1'b1;
        repeat (40) @(posedge pclk);
        stop_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(ad(IDX_FLAGS));
        chk(rv, 32'h0);
        wflag(16'h000F);
        for (int f = 0; f < 2; f++)
        begin
            wr(ad(IDX_CTRL), f ? 32'h43 : 32'h40);
            freeze_mode <= 1'b1;
            repeat (5) @(posedge pclk);
            wr(ad(IDX_START), 32'h03);
            repeat (300) @(posedge pclk);
            rd(ad(IDX_FLAGS));
            chk(rv, f ? 32'h0 : 32'hF);
            freeze_mode <= 1'b0;
            wflag(16'h000F);
        end
        // Freeze raised while the second sample counts: that conversion ends, the third never starts.
        wr(ad(IDX_CTRL), 32'h42);
        wr(ad(IDX_START), 32'h03);
        wflag(16'h0001);
        freeze_mode <= 1'b1;
        repeat (300) @(posedge pclk);
        rd(ad(IDX_FLAGS));
        chk(rv, 32'h3);
        freeze_mode <= 1'b0;
        wflag(16'h000F);
        print_verdict();
    end
endmodule
bind asc_seq_ctrl asc_seq_ctrl_props u_props (.*);
`default_nettype wire
